// ### design/eep_pkg.sv
// shared constants and types for the two-wire eeprom slave and its bus master
package eep_pkg;
   // array organisation
   localparam int ADDR_W = 10;
   localparam int PAGE_W = 4;
   localparam int DEPTH = 1024;
   localparam logic [3:0] DEV_CODE = 4'ha;
   // clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_TIME_MS = 3;
   localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SCL_QUARTER_NS = 250;
   localparam int SCL_QUARTER_CYCLES = (SCL_QUARTER_NS / CLK_PERIOD_NS < 1) ? 1 :
                                       SCL_QUARTER_NS / CLK_PERIOD_NS;
   localparam int BYTE_BITS = 8;
   localparam int RECOVER_BITS = 9;
   // synchroniser reset levels: {guard, strap, sda, scl}, idle bus is high
   localparam logic [3:0] DEV_SYNC_RST = 4'h3;
   localparam logic MST_SYNC_RST = 1'b1;
   // controller register map (byte addresses)
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   // command register fields
   localparam int CMD_DATA_LSB = 0;
   localparam int CMD_NACK_BIT = 8;
   localparam int CMD_OP_LSB = 12;
   // status register fields
   localparam int ST_RX_LSB = 0;
   localparam int ST_ACK_BIT = 8;
   localparam int ST_BUSY_BIT = 9;
   localparam logic [31:0] RDATA_RST = 32'h0;
   // controller commands
   typedef enum logic [2:0] {OP_START, OP_STOP, OP_WRITE, OP_READ, OP_RECOVER} eep_op_e;
endpackage

// ### design/eep_if.sv
// open-drain two-wire link between the eeprom slave and its bus master
`timescale 1ns/10ps
interface eep_if;
   logic scl_o;    // master clock level when driving
   logic scl_oe;   // master drives clock
   logic m_sda_o;  // master data level when driving
   logic m_sda_oe; // master drives data
   logic d_sda_o;  // slave data level when driving
   logic d_sda_oe; // slave drives data
   logic scl;      // resolved clock wire
   logic sda;      // resolved data wire
   // pull-up resolution: any driver pulling low wins
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
   modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
   modport mst (input sda, output scl_o, output scl_oe, output m_sda_o, output m_sda_oe);
endinterface

// ### design/eep_dev.sv
// two-wire serial eeprom slave with 1024-byte array, paged writes and timed program cycle
//
// Function
// - 1024 bytes, 64 pages of 16, 10-bit address
// - data changes only while clock low
// - falling data with clock high starts
// - rising data with clock high stops
// - eight-bit words, ninth clock acknowledged low
// - standby at power-up and after stop
// - master recovers with nine clocks, then start
// - device address opens with fixed pattern
// - strap bit compared with strap pin
// - eighth address bit selects read or write
// - match acknowledges, mismatch returns to standby
// - write guard high blocks all writes
// - byte write: address, word, data, stop
// - stop after write starts 3 ms program
// - page write takes up to sixteen bytes
// - writes wrap within lower four address bits
// - polling acknowledged only after program completes
// - address counter holds last plus one
// - current read: one byte, no ack, stop
// - random read uses dummy write, restart
// - master ack continues sequential read
// - sample rising, change falling, open-drain low
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
module eep_dev
   import eep_pkg::*;
#(
   parameter int PROG_CYCLES_P = PROG_CYCLES
) (
   input wire logic clk_sys,           // system clock
   input wire logic rst,               // synchronous reset, active high
   input wire logic ce,                // clock enable, freezes all state when low
   eep_if.dev bus,                     // two-wire link
   input wire logic chip_select_strap, // hardwired strap pin
   input wire logic write_guard,       // high blocks array writes
   output logic standby,               // idle, waiting for a start
   output logic prog_busy              // program cycle running
);

   typedef enum logic [2:0] {
      ST_IDLE, ST_DEVADR, ST_WORDADR, ST_WDATA, ST_RDPEND, ST_RDATA, ST_PROG
   } eep_dstate_e;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three flops, a change counts once second and third agree

   logic [3:0] pin_raw;
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_s3;
   logic [3:0] pin_f;
   logic [3:0] pin_q;

   assign pin_raw = {write_guard, chip_select_strap, bus.sda, bus.scl};

   // the filter also eats single-cycle glitches on the pins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_s1 <= DEV_SYNC_RST;
         pin_s2 <= DEV_SYNC_RST;
         pin_s3 <= DEV_SYNC_RST;
         pin_f <= DEV_SYNC_RST;
         pin_q <= DEV_SYNC_RST;
      end else if (ce) begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f <= ((pin_s2 ~^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);
         pin_q <= pin_f;
      end
   end

   logic scl_f;
   logic sda_f;
   logic strap_f;
   logic guard_f;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   assign scl_f = pin_f[0];
   assign sda_f = pin_f[1];
   assign strap_f = pin_f[2];
   assign guard_f = pin_f[3];
   assign scl_rise = scl_f && !pin_q[0];
   assign scl_fall = !scl_f && pin_q[0];
   // data edges while clock stays high are bus conditions, not data
   assign start_c = scl_f && pin_q[0] && pin_q[1] && !sda_f;
   assign stop_c = scl_f && pin_q[0] && !pin_q[1] && sda_f;

   ////////////////////////////////////////////////////////////////////////////////
   // protocol state

   eep_dstate_e state;
   logic [3:0] cnt;
   logic ack_ph;
   logic sda_low;
   logic [7:0] rx;
   logic [7:0] tx;
   logic [ADDR_W-1:0] addr;
   logic [1:0] addr_hi;
   logic wrote;
   logic [31:0] prog_cnt;
   logic [7:0] mem [DEPTH];
   logic byte_we;
   logic dev_match;

   assign dev_match = (rx[7:4] == DEV_CODE) && (rx[3] == strap_f);
   // the array takes a byte at its ack point unless guarded
   assign byte_we = scl_fall && (state == ST_WDATA) && (cnt == 4'd8) && !ack_ph
                    && !guard_f;

   // array write port, one byte per acknowledged data word
   always_ff @(posedge clk_sys) begin
      if (ce && byte_we) begin
         mem[addr] <= rx;
      end
   end

   // main sequencer; the program cycle shuts out every input until it ends
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         ack_ph <= 1'b0;
         sda_low <= 1'b0;
         rx <= 8'h00;
         tx <= 8'h00;
         addr <= '0;
         addr_hi <= 2'h0;
         wrote <= 1'b0;
         prog_cnt <= 32'h0;
      end else if (ce) begin
         if (state == ST_PROG) begin
            sda_low <= 1'b0;
            if (prog_cnt == 32'h0) begin
               state <= ST_IDLE;
            end else begin
               prog_cnt <= prog_cnt - 32'h1;
            end
         end else if (start_c) begin
            state <= ST_DEVADR;
            cnt <= 4'h0;
            ack_ph <= 1'b0;
            sda_low <= 1'b0;
            wrote <= 1'b0;
         end else if (stop_c) begin
            sda_low <= 1'b0;
            ack_ph <= 1'b0;
            wrote <= 1'b0;
            if (wrote) begin
               state <= ST_PROG;
               prog_cnt <= 32'(PROG_CYCLES_P - 1);
            end else begin
               state <= ST_IDLE;
            end
         end else if (scl_rise) begin
            // incoming bits are taken on the rising clock
            if (state == ST_RDATA) begin
               if (cnt != 4'd8) begin
                  cnt <= cnt + 4'h1;
               end else if (sda_f) begin
                  state <= ST_IDLE;
               end else begin
                  cnt <= 4'h0;
                  tx <= mem[addr];
                  addr <= addr + 1'b1;
               end
            end else if ((state == ST_DEVADR || state == ST_WORDADR || state == ST_WDATA)
                         && cnt != 4'd8) begin
               rx <= {rx[6:0], sda_f};
               cnt <= cnt + 4'h1;
            end
         end else if (scl_fall) begin
            // outgoing level changes only after the falling clock
            if (state == ST_RDATA) begin
               if (cnt != 4'd8) begin
                  sda_low <= !tx[3'(4'd7 - cnt)];
               end else begin
                  sda_low <= 1'b0; // leave the ninth bit to the master
               end
            end else if (ack_ph) begin
               ack_ph <= 1'b0;
               cnt <= 4'h0;
               if (state == ST_RDPEND) begin
                  state <= ST_RDATA;
                  tx <= mem[addr];
                  addr <= addr + 1'b1;
                  sda_low <= !mem[addr][7];
               end else begin
                  sda_low <= 1'b0;
               end
            end else if (cnt == 4'd8) begin
               case (state)
                  ST_DEVADR: begin
                     if (dev_match) begin
                        sda_low <= 1'b1;
                        ack_ph <= 1'b1;
                        addr_hi <= rx[2:1];
                        state <= rx[0] ? ST_RDPEND : ST_WORDADR;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
                  ST_WORDADR: begin
                     sda_low <= 1'b1;
                     ack_ph <= 1'b1;
                     addr <= {addr_hi, rx};
                     state <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     sda_low <= 1'b1;
                     ack_ph <= 1'b1;
                     // page wrap: upper bits hold the page row
                     addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 1'b1;
                     if (!guard_f) begin
                        wrote <= 1'b1;
                     end
                  end
                  default: begin
                     state <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered outputs

   logic sda_lvl;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sda_lvl <= 1'b0;
         standby <= 1'b1;
         prog_busy <= 1'b0;
      end else if (ce) begin
         sda_lvl <= 1'b0; // only ever pulls low
         standby <= (state == ST_IDLE);
         prog_busy <= (state == ST_PROG);
      end
   end

   assign bus.d_sda_o = sda_lvl;
   assign bus.d_sda_oe = sda_low;

endmodule

// ### design/eep_mst.sv
// two-wire bus master, ordered one bus step at a time through avalon registers
`timescale 1ns/10ps
module eep_mst
   import eep_pkg::*;
#(
   parameter int QUARTER_P = SCL_QUARTER_CYCLES
) (
   input wire logic clk_sys,              // system clock
   input wire logic rst,                  // synchronous reset, active high
   input wire logic ce,                   // clock enable, freezes all state when low
   input wire logic [3:0] avs_address,    // byte address
   input wire logic avs_read,             // read request
   input wire logic avs_write,            // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata,      // read data
   output logic avs_waitrequest,          // stall until low
   eep_if.mst bus                         // two-wire link
);

   typedef enum logic {MS_IDLE, MS_RUN} eep_mstate_e;

   ////////////////////////////////////////////////////////////////////////////////
   // data line synchroniser, three flops with agreement filter

   logic sda_s1;
   logic sda_s2;
   logic sda_s3;
   logic sda_f;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sda_s1 <= MST_SYNC_RST;
         sda_s2 <= MST_SYNC_RST;
         sda_s3 <= MST_SYNC_RST;
         sda_f <= MST_SYNC_RST;
      end else if (ce) begin
         sda_s1 <= bus.sda;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         if (sda_s2 == sda_s3) begin
            sda_f <= sda_s3;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, a command write stalls while a step runs

   eep_mstate_e mstate;
   logic [7:0] rx_byte;
   logic last_ack;
   logic busy;
   logic blocked;
   logic go;
   logic [31:0] status_w;

   assign busy = (mstate == MS_RUN);
   assign blocked = avs_write && (avs_address == REG_CMD) && busy;
   assign go = avs_write && !avs_waitrequest && (avs_address == REG_CMD);

   always_comb begin
      status_w = RDATA_RST;
      status_w[ST_RX_LSB +: 8] = rx_byte;
      status_w[ST_ACK_BIT] = last_ack;
      status_w[ST_BUSY_BIT] = busy;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= RDATA_RST;
      end else if (ce) begin
         if ((avs_read || avs_write) && avs_waitrequest && !blocked) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= (avs_read && avs_address == REG_STATUS) ? status_w : RDATA_RST;
         end else begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus step engine: each bit is four quarters of the link clock it makes

   eep_op_e op;
   logic [8:0] tx9;
   logic [8:0] rx9;
   logic [1:0] quarter;
   logic [15:0] qcnt;
   logic [3:0] bitn;
   logic rec_hit;
   logic scl_low;
   logic sda_low;
   logic line_lvl;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mstate <= MS_IDLE;
         op <= OP_START;
         tx9 <= 9'h1ff;
         rx9 <= 9'h000;
         quarter <= 2'h0;
         qcnt <= 16'h0;
         bitn <= 4'h0;
         rec_hit <= 1'b0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         rx_byte <= 8'h00;
         last_ack <= 1'b0;
         line_lvl <= 1'b0;
      end else if (ce) begin
         line_lvl <= 1'b0; // open drain: drives low only
         if (go) begin
            mstate <= MS_RUN;
            op <= eep_op_e'(avs_writedata[CMD_OP_LSB +: 3]);
            case (eep_op_e'(avs_writedata[CMD_OP_LSB +: 3]))
               OP_WRITE: tx9 <= {avs_writedata[CMD_DATA_LSB +: 8], 1'b1};
               OP_READ: tx9 <= {8'hff, avs_writedata[CMD_NACK_BIT]};
               default: tx9 <= 9'h1ff;
            endcase
            quarter <= 2'h0;
            qcnt <= 16'h0;
            bitn <= 4'h0;
            rec_hit <= 1'b0;
         end else if (mstate == MS_RUN) begin
            if (qcnt != 16'(QUARTER_P - 1)) begin
               qcnt <= qcnt + 16'h1;
            end else begin
               qcnt <= 16'h0;
               quarter <= quarter + 2'h1;
               case (op)
                  OP_START: begin
                     // data falls while clock high; works as a repeated start too
                     case (quarter)
                        2'd0: sda_low <= 1'b0;
                        2'd1: scl_low <= 1'b0;
                        2'd2: sda_low <= 1'b1;
                        default: begin
                           scl_low <= 1'b1;
                           mstate <= MS_IDLE;
                        end
                     endcase
                  end
                  OP_STOP: begin
                     case (quarter)
                        2'd0: sda_low <= 1'b1;
                        2'd1: scl_low <= 1'b0;
                        2'd2: sda_low <= 1'b0;
                        default: mstate <= MS_IDLE;
                     endcase
                  end
                  default: begin
                     // data changes only in the low quarter of the clock
                     case (quarter)
                        2'd0: sda_low <= !tx9[8];
                        2'd1: scl_low <= 1'b0;
                        2'd2: begin
                           rx9 <= {rx9[7:0], sda_f};
                           tx9 <= {tx9[7:0], 1'b1};
                           rec_hit <= (op == OP_RECOVER) && sda_f;
                        end
                        default: begin
                           scl_low <= 1'b1;
                           if (bitn == 4'(RECOVER_BITS - 1) || rec_hit) begin
                              mstate <= MS_IDLE;
                              last_ack <= !rx9[0];
                              rx_byte <= rx9[8:1];
                           end else begin
                              bitn <= bitn + 4'h1;
                           end
                        end
                     endcase
                  end
               endcase
            end
         end
      end
   end

   assign bus.scl_o = line_lvl;
   assign bus.scl_oe = scl_low;
   assign bus.m_sda_o = line_lvl;
   assign bus.m_sda_oe = sda_low;

endmodule

// ### dv/eep_link_asserts.sv
// link-level assertions watching both ends of the two-wire eeprom link
`timescale 1ns/10ps
module eep_link_asserts #(
   parameter int PROG = 200
) (
   input wire logic clk_sys,  // system clock
   input wire logic rst,      // sync reset, active high
   input wire logic scl,      // resolved clock wire
   input wire logic sda,      // resolved data wire
   input wire logic scl_o,    // master clock level
   input wire logic scl_oe,   // master clock drive
   input wire logic m_sda_o,  // master data level
   input wire logic m_sda_oe, // master data drive
   input wire logic d_sda_o,  // slave data level
   input wire logic d_sda_oe, // slave data drive
   input wire logic standby,  // slave idle
   input wire logic prog_busy // slave program cycle
);
   int busy_cnt;
   int since_stop;
   logic sda_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence start_cond;
      scl && $fell(sda);
   endsequence
   sequence stop_cond;
      scl && $rose(sda);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // helper counters; since_stop saturates so it never wraps into a false match
   always_ff @(posedge clk_sys) begin
      busy_cnt <= (rst || !prog_busy) ? 0 : busy_cnt + 1;
   end
   always_ff @(posedge clk_sys) begin
      sda_q <= sda;
      if (rst) begin
         since_stop <= 1000;
      end else if (scl && sda && !sda_q) begin
         since_stop <= 0;
      end else if (since_stop < 1000) begin
         since_stop <= since_stop + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   chk_dev_open_drain: assert property (d_sda_oe |-> !d_sda_o)
      else $error("slave drives data high");
   chk_mst_drive_low: assert property ((m_sda_oe || scl_oe) |-> (!m_sda_o && !scl_o))
      else $error("master drives a wire high");
   chk_ack_scl_low: assert property ($changed(d_sda_oe) |-> !scl)
      else $error("slave data changed with clock high");
   chk_busy_no_ack: assert property (prog_busy |-> !d_sda_oe)
      else $error("slave answered during program cycle");
   chk_prog_after_stop: assert property ($rose(prog_busy) |-> since_stop <= 12)
      else $error("program cycle began without a stop");
   chk_prog_length: assert property ($fell(prog_busy) |->
      ($past(busy_cnt) >= PROG - 2 && $past(busy_cnt) <= PROG + 1))
      else $error("program cycle length wrong");
   chk_standby_return: assert property ($fell(prog_busy) |-> ##[0:3] standby)
      else $error("no standby after program cycle");
   chk_start_wakes: assert property (start_cond ##0 (standby && !prog_busy)
      |-> ##[1:12] !standby)
      else $error("start did not wake the slave");
   chk_stop_idles: assert property (stop_cond |-> ##[1:12] (standby || prog_busy))
      else $error("stop did not idle the slave");
endmodule

// ### dv/eep_bench.sv
// self-checking bench: avalon-driven master talking to the eeprom slave
`timescale 1ns/10ps
module eep_bench
   import eep_pkg::*;
;
   localparam int PROG = 2000; // short program time keeps the run brief
   localparam int LIMIT = 70000;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic write_guard = 1'b0;
   logic strap = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic standby;
   logic prog_busy;
   logic [31:0] st;
   logic [7:0] rx;
   logic [7:0] exp_pg [16];
   logic ack;
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   eep_if link();
   eep_mst #(.QUARTER_P(10)) eep_mst_i (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .bus(link.mst));
   eep_dev #(.PROG_CYCLES_P(PROG)) eep_dev_i (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .bus(link.dev), .chip_select_strap(strap), .write_guard(write_guard),
      .standby(standby), .prog_busy(prog_busy));
   eep_link_asserts #(.PROG(PROG)) eep_link_asserts_i (.clk_sys(clk_sys), .rst(rst),
      .scl(link.scl), .sda(link.sda), .scl_o(link.scl_o), .scl_oe(link.scl_oe),
      .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe), .d_sda_o(link.d_sda_o),
      .d_sda_oe(link.d_sda_oe), .standby(standby), .prog_busy(prog_busy));
   always #5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard: a stuck handshake ends the run as a failure
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("counts: %0d compared, %0d bad", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // avalon access: request held until waitrequest is seen low at an edge
   task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] wd,
      output logic [31:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= wd;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // one bus step, then poll until the master is no longer busy
   task automatic step(input eep_op_e op, input logic [7:0] d, input logic nack);
      logic [31:0] q;
      av(1'b0, REG_CMD, {17'h0, op, 3'h0, nack, d}, q);
      do av(1'b1, REG_STATUS, 32'h0, st); while (st[ST_BUSY_BIT] !== 1'b0);
   endtask
   task automatic put(input logic [7:0] b, input logic e);
      step(OP_WRITE, b, 1'b0);
      chk_bit("ack", e, st[ST_ACK_BIT]);
   endtask
   task automatic get(input logic nack);
      step(OP_READ, 8'h00, nack);
      rx = st[7:0];
   endtask
   task automatic wr_byte(input logic [9:0] a, input logic [7:0] d);
      step(OP_START, 8'h00, 1'b0);
      put({DEV_CODE, 1'b0, a[9:8], 1'b0}, 1'b1);
      put(a[7:0], 1'b1);
      put(d, 1'b1);
      step(OP_STOP, 8'h00, 1'b0);
   endtask
   task automatic wait_prog();
      repeat (20) @(posedge clk_sys);
      chk_bit("program running", 1'b1, prog_busy);
      for (n = 0; n < PROG + 100 && prog_busy !== 1'b0; n++) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      chk_bit("program done", 1'b0, prog_busy);
      chk_bit("standby", 1'b1, standby);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk_bit("standby at reset", 1'b1, standby);
      $display("test reset done");
      wr_byte(10'h000, 8'h3c);
      wait_prog();
      // guarded write is acked but starts no program cycle
      write_guard <= 1'b1;
      wr_byte(10'h000, 8'hc3);
      repeat (30) @(posedge clk_sys);
      chk_bit("guarded busy", 1'b0, prog_busy);
      write_guard <= 1'b0;
      $display("test guard done");
      // byte write then acknowledge polling into a random read
      wr_byte(10'h2f5, 8'h5a);
      step(OP_START, 8'h00, 1'b0);
      put(8'ha4, 1'b0);
      n = 0;
      do begin
         step(OP_START, 8'h00, 1'b0);
         step(OP_WRITE, 8'ha4, 1'b0);
         n++;
      end while (st[ST_ACK_BIT] !== 1'b1 && n < 20);
      chk_bit("poll ack", 1'b1, st[ST_ACK_BIT]);
      put(8'hf5, 1'b1);
      step(OP_START, 8'h00, 1'b0);
      put(8'ha5, 1'b1);
      get(1'b1);
      chk_byte("random read", 8'h5a, rx);
      step(OP_STOP, 8'h00, 1'b0);
      $display("test poll done");
      // page write of 18 bytes from offset 14 wraps inside the page
      step(OP_START, 8'h00, 1'b0);
      put(8'ha6, 1'b1);
      put(8'hfe, 1'b1);
      for (int i = 0; i < 18; i++) begin
         put(8'h10 + 8'(i), 1'b1);
         exp_pg[(14 + i) % 16] = 8'h10 + 8'(i);
      end
      step(OP_STOP, 8'h00, 1'b0);
      wait_prog();
      step(OP_START, 8'h00, 1'b0);
      put(8'ha6, 1'b1);
      put(8'hf0, 1'b1);
      step(OP_START, 8'h00, 1'b0);
      put(8'ha7, 1'b1);
      for (int i = 0; i < 16; i++) begin
         get(i == 15);
         chk_byte("page byte", exp_pg[i], rx);
      end
      step(OP_STOP, 8'h00, 1'b0);
      // counter wrapped to zero; guarded byte must not have landed
      step(OP_START, 8'h00, 1'b0);
      put(8'ha1, 1'b1);
      get(1'b1);
      chk_byte("current read", 8'h3c, rx);
      step(OP_STOP, 8'h00, 1'b0);
      $display("test page done");
      // strap mismatch is ignored, then bus recovery
      step(OP_START, 8'h00, 1'b0);
      put(8'ha8, 1'b0);
      step(OP_STOP, 8'h00, 1'b0);
      // the same address is answered once the strap pin is raised
      strap <= 1'b1;
      step(OP_START, 8'h00, 1'b0);
      put(8'ha8, 1'b1);
      step(OP_STOP, 8'h00, 1'b0);
      step(OP_RECOVER, 8'h00, 1'b0);
      chk_bit("bus free", 1'b0, st[ST_ACK_BIT]);
      $display("test mismatch done");
      report_and_stop();
   end
endmodule
